/* lcrc_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module lcrc_cell (
    input  wire logic mclk_i,     // system clock
    input  wire logic sys_rst_i,  // sync reset
    input  wire logic dev_clr_i,  // device-wide clear, active high here
    input  wire logic tick_i,     // gated edge of this cell's cluster clock
    input  wire logic aclr_i,     // selected asynchronous clear
    input  wire logic sclr_i,     // cluster sync clear
    input  wire logic sload_i,    // cluster sync load
    input  wire logic sdata_i,    // sync load value
    input  wire logic lut_i,      // lookup-table result
    input  wire logic chain_i,    // previous cell register
    input  wire logic chain_sel_i,// capture from chain
    input  wire logic preset_i,   // preset mode
    input  wire logic comb_i,     // register bypass
    output logic      reg_o,      // register value
    output logic      cell_o      // cell output
);
    logic q_q;
    logic d_in;

    assign d_in = chain_sel_i ? chain_i : lut_i;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || dev_clr_i || aclr_i) begin
            q_q <= 1'b0;
        end else if (tick_i) begin
            if (sclr_i) begin
                q_q <= 1'b0;
            end else if (sload_i) begin
                q_q <= sdata_i ^ preset_i;
            end else begin
                q_q <= d_in ^ preset_i;
            end
        end
    end

    // preset cells store inverted data so a clear reads back as one
    assign reg_o  = q_q ^ preset_i;
    assign cell_o = comb_i ? lut_i : reg_o;
endmodule : lcrc_cell
`default_nettype wire

/* lcrc_fab.sv */
`timescale 1ns/1ps
`default_nettype none
module lcrc_fab
    import lcrc_pkg::*;
(
    input  wire logic             mclk_i, // system clock
    output logic      [NROW-1:0]  row_o,  // row clock lines
    output logic      [NRTE-1:0]  rte_o,  // routing into local lines
    output logic      [NCELL-1:0] lut_o,  // lookup-table results
    output logic      [NCELL-1:0] sd_o,   // sync load data
    output logic      [NCELL-1:0] lf_o,   // direct links from left block
    output logic      [NCELL-1:0] rt_o,   // direct links from right block
    output logic                  ch_o    // chain into cell 0
);
    initial begin
        row_o = '0;
        rte_o = '0;
        lut_o = '0;
        sd_o = '0;
        lf_o = '0;
        rt_o = '0;
        ch_o = 1'b0;
    end
    // line numbers: row clocks, then routing, then left links, then right links
    task line(input int n, input logic v);
        @(posedge mclk_i);
        if (n < NROW) begin
            row_o[n] <= v;
        end else if (n < NROW + NRTE) begin
            rte_o[n-NROW] <= v;
        end else if (n < NROW + NRTE + NCELL) begin
            lf_o[n-NROW-NRTE] <= v;
        end else begin
            rt_o[n-NROW-NRTE-NCELL] <= v;
        end
    endtask : line
    task put(input logic [15:0] lookup_table, input logic [15:0] sd, input logic ch);
        @(posedge mclk_i);
        lut_o <= lookup_table;
        sd_o  <= sd;
        ch_o  <= ch;
    endtask : put
    // one slow swing: the source must fall before another edge
    task pulse(input int n);
        line(n, 1'b1);
        repeat (2) @(posedge mclk_i);
        line(n, 1'b0);
        repeat (3) @(posedge mclk_i);
    endtask : pulse
endmodule : lcrc_fab
`default_nettype wire

/* lcrc_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module lcrc_mux #(
    parameter int N  = 14,
    parameter int SW = 4
) (
    input  wire logic [N-1:0]  src_i,   // candidate lines
    input  wire logic [SW-1:0] sel_i,   // line index
    output logic               out_o    // selected line, low when out of range
);
    assign out_o = (int'(sel_i) < N) ? src_i[sel_i] : 1'b0;
endmodule : lcrc_mux
`default_nettype wire

/* lcrc_pkg.sv */
// Behaviour
// - two clocks, two gates, two clears, sclr, sload
// - sync load disables first clock gate
// - register packing blocks the sync load
// - at most four non-global control sources
// - sync clear/load hit all cluster registers
// - each cell clock paired with its gate
// - both edges need both cluster clocks
// - gate low stops its paired clock
// - controls come from row clocks or local lines
// - no async load; preset by inverted data
// - optional device-wide clear overrides everything
// - register chain feeds the next cell
// - local lines from routing, cells, neighbours
// - each cell output reaches 48 cells
// - cell register with bypass for combinational
package lcrc_pkg;
    localparam int NCELL = 16;
    localparam int NROW  = 6;
    localparam int NLOC  = 8;
    localparam int NRTE  = 8;
    localparam int NPOOL = NRTE + 3 * NCELL;
    localparam int SRCW  = 4;
    localparam int LOCW  = 6;
    localparam int NCTRL = 8;
    localparam int MAX_NONGLOBAL = 4;
    localparam int MAX_ACTIVE    = 7;

    localparam logic [SRCW-1:0] SRC_NONE = 4'hF;
    localparam logic [SRCW-1:0] LOC_BASE = 4'h6;

    // control slots, one nibble each in the source register
    typedef enum logic [2:0] {
        LCRC_CLK_A, LCRC_GATE_A, LCRC_CLK_B, LCRC_GATE_B,
        LCRC_ACLR0, LCRC_ACLR1, LCRC_SCLR, LCRC_SLOAD
    } lcrc_ctrl_t;

    localparam logic [7:0] A_SRC      = 8'h00;
    localparam logic [7:0] A_MODE     = 8'h04;
    localparam logic [7:0] A_CELL_CLK = 8'h08;
    localparam logic [7:0] A_CELL_CLR = 8'h0C;
    localparam logic [7:0] A_CELL_MOD = 8'h10;
    localparam logic [7:0] A_LOC0     = 8'h14;
    localparam logic [7:0] A_LOC1     = 8'h18;
    localparam logic [7:0] A_STATUS   = 8'h1C;
    localparam logic [7:0] A_QOUT     = 8'h20;

    localparam logic [31:0] SRC_RST  = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_RST = 32'h00000000;

    localparam int M_FALL_A = 0;
    localparam int M_FALL_B = 1;
    localparam int M_PACK   = 2;
    localparam int HALF     = 16;

    function automatic logic is_nonglobal(input logic [SRCW-1:0] sel);
        is_nonglobal = (sel >= LOC_BASE) && (sel != SRC_NONE);
    endfunction : is_nonglobal
endpackage : lcrc_pkg

/* lcrc_top.sv */
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcrc_top
    import lcrc_pkg::*;
#(
    parameter bit DEV_CLR_EN = 1'b1
) (
    input  wire logic              mclk_i,      // 25 MHz system clock
    input  wire logic              sys_rst_i,   // sync reset, active high
    input  wire logic              dev_clr_n_i, // device_wide_clear_n
    input  wire logic [NROW-1:0]   row_clk_i,   // row clock lines
    input  wire logic [NRTE-1:0]   route_i,     // row/column routing into local lines
    input  wire logic [NCELL-1:0]  left_i,      // direct links from left block
    input  wire logic [NCELL-1:0]  right_i,     // direct links from right block
    input  wire logic [NCELL-1:0]  lut_i,       // lookup-table results
    input  wire logic [NCELL-1:0]  sdata_i,     // sync load data
    input  wire logic              chain_i,     // chain into first cell
    input  wire logic [7:0]        addr_i,      // register address
    input  wire logic [31:0]       wdata_i,     // write data
    input  wire logic              wr_i,        // write strobe
    input  wire logic              rd_i,        // read strobe
    output logic      [31:0]       rdata_o,     // read data, cycle after rd_i
    output logic      [NCELL-1:0]  cell_o,      // cell outputs
    output logic      [NCELL-1:0]  reg_o,       // register outputs
    output logic      [NCELL-1:0]  dlink_l_o,   // direct links to left block
    output logic      [NCELL-1:0]  dlink_r_o,   // direct links to right block
    output logic                   chain_o      // chain out of last cell
);
    logic [31:0] src_q;
    logic [31:0] mode_q;
    logic [31:0] cclk_q;
    logic [31:0] cclr_q;
    logic [31:0] cmod_q;
    logic [31:0] loc0_q;
    logic [31:0] loc1_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        clk_a_prev_q;
    logic        clk_b_prev_q;

    // register port
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            src_q  <= SRC_RST;
            mode_q <= ZERO_RST;
            cclk_q <= ZERO_RST;
            cclr_q <= ZERO_RST;
            cmod_q <= ZERO_RST;
            loc0_q <= ZERO_RST;
            loc1_q <= ZERO_RST;
        end else if (wr_i) begin
            case (addr_i)
                A_SRC:      src_q  <= wdata_i;
                A_MODE:     mode_q <= wdata_i;
                A_CELL_CLK: cclk_q <= wdata_i;
                A_CELL_CLR: cclr_q <= wdata_i;
                A_CELL_MOD: cmod_q <= wdata_i;
                A_LOC0:     loc0_q <= wdata_i;
                A_LOC1:     loc1_q <= wdata_i;
                default:    ;
            endcase
        end
    end

    // local lines: pool of routing, own cells and both neighbours
    logic [NPOOL-1:0]       pool;
    logic [NLOC-1:0]        loc_line;
    logic [NLOC*LOCW-1:0]   loc_sel;

    assign pool    = {right_i, left_i, cell_o, route_i};
    assign loc_sel = {loc1_q[4*LOCW-1:0], loc0_q[4*LOCW-1:0]};

    genvar gl;
    generate
        for (gl = 0; gl < NLOC; gl++) begin : g_loc
            lcrc_mux #(.N(NPOOL), .SW(LOCW)) u_loc (
                .src_i (pool),
                .sel_i (loc_sel[gl*LOCW +: LOCW]),
                .out_o (loc_line[gl])
            );
        end
    endgenerate

    // control slot selection and admission
    logic [NROW+NLOC-1:0] ctrl_pool;
    logic [NCTRL-1:0]     raw;
    logic [NCTRL-1:0]     used;
    logic [NCTRL-1:0]     ng;
    logic [NCTRL-1:0]     keep;
    logic [NCTRL-1:0]     eff;
    logic [3:0]           ng_pfx [NCTRL+1];
    logic [3:0]           act_cnt[NCTRL+1];
    logic                 pack_en;
    logic                 sload_req;
    logic                 sload_ok;
    logic                 gate_a_off;

    assign ctrl_pool = {loc_line, row_clk_i};
    assign pack_en   = mode_q[M_PACK];
    assign sload_req = src_q[int'(LCRC_SLOAD)*SRCW +: SRCW] != SRC_NONE;
    assign sload_ok  = sload_req && !pack_en;
    assign gate_a_off = sload_ok;
    assign ng_pfx[0]  = 4'h0;
    assign act_cnt[0] = 4'h0;

    genvar gc;
    generate
        for (gc = 0; gc < NCTRL; gc++) begin : g_ctrl
            lcrc_mux #(.N(NROW+NLOC), .SW(SRCW)) u_src (
                .src_i (ctrl_pool),
                .sel_i (src_q[gc*SRCW +: SRCW]),
                .out_o (raw[gc])
            );
            assign used[gc] = src_q[gc*SRCW +: SRCW] != SRC_NONE;
            assign ng[gc]   = is_nonglobal(src_q[gc*SRCW +: SRCW]);
            // non-global sources past the fourth are dropped in slot order
            assign keep[gc] = used[gc] && !(ng[gc] && (ng_pfx[gc] >= 4'(MAX_NONGLOBAL)));
            assign ng_pfx[gc+1] = ng_pfx[gc] + 4'(keep[gc] && ng[gc]);
            assign act_cnt[gc+1] = act_cnt[gc] + 4'(eff[gc]);
        end
    endgenerate

    always_comb begin
        eff = keep;
        eff[LCRC_SLOAD]  = keep[LCRC_SLOAD] && sload_ok;
        eff[LCRC_GATE_A] = keep[LCRC_GATE_A] && !gate_a_off;
    end

    // effective control levels
    logic src_clk_a;
    logic src_clk_b;
    logic gate_a;
    logic gate_b;
    logic aclr0;
    logic aclr1;
    logic sclr;
    logic sload;
    logic edge_a;
    logic edge_b;
    logic tick_a;
    logic tick_b;
    logic dev_clr;

    assign src_clk_a = eff[LCRC_CLK_A] && raw[LCRC_CLK_A];
    assign src_clk_b = eff[LCRC_CLK_B] && raw[LCRC_CLK_B];
    // an unused gate leaves its clock running
    assign gate_a = !eff[LCRC_GATE_A] || raw[LCRC_GATE_A];
    assign gate_b = !eff[LCRC_GATE_B] || raw[LCRC_GATE_B];
    assign aclr0  = eff[LCRC_ACLR0] && raw[LCRC_ACLR0];
    assign aclr1  = eff[LCRC_ACLR1] && raw[LCRC_ACLR1];
    assign sclr   = eff[LCRC_SCLR] && raw[LCRC_SCLR];
    assign sload  = eff[LCRC_SLOAD] && raw[LCRC_SLOAD];
    assign dev_clr = DEV_CLR_EN && !dev_clr_n_i;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            clk_a_prev_q <= 1'b0;
            clk_b_prev_q <= 1'b0;
        end else begin
            clk_a_prev_q <= src_clk_a;
            clk_b_prev_q <= src_clk_b;
        end
    end

    // each cluster clock picks its edge, so one source can feed both
    assign edge_a = mode_q[M_FALL_A] ? (clk_a_prev_q && !src_clk_a)
                                     : (!clk_a_prev_q && src_clk_a);
    assign edge_b = mode_q[M_FALL_B] ? (clk_b_prev_q && !src_clk_b)
                                     : (!clk_b_prev_q && src_clk_b);
    assign tick_a = edge_a && gate_a;
    assign tick_b = edge_b && gate_b;

    // the cells
    logic [NCELL-1:0] on_b;
    logic [NCELL-1:0] clr_sel;
    logic [NCELL-1:0] preset;
    logic [NCELL-1:0] comb;
    logic [NCELL-1:0] chain_sel;
    logic [NCELL-1:0] chain_in;
    logic [NCELL-1:0] cell_tick;
    logic [NCELL-1:0] cell_aclr;

    assign on_b      = cclk_q[NCELL-1:0];
    assign clr_sel   = cclr_q[NCELL-1:0];
    assign preset    = cclr_q[HALF +: NCELL];
    assign comb      = cmod_q[NCELL-1:0];
    assign chain_sel = cmod_q[HALF +: NCELL];
    assign chain_in  = {reg_o[NCELL-2:0], chain_i};
    assign cell_tick = (~on_b & {NCELL{tick_a}}) | (on_b & {NCELL{tick_b}});
    assign cell_aclr = (~clr_sel & {NCELL{aclr0}}) | (clr_sel & {NCELL{aclr1}});

    genvar gi;
    generate
        for (gi = 0; gi < NCELL; gi++) begin : g_cell
            lcrc_cell u_cell (
                .mclk_i      (mclk_i),
                .sys_rst_i   (sys_rst_i),
                .dev_clr_i   (dev_clr),
                .tick_i      (cell_tick[gi]),
                .aclr_i      (cell_aclr[gi]),
                .sclr_i      (sclr),
                .sload_i     (sload),
                .sdata_i     (sdata_i[gi]),
                .lut_i       (lut_i[gi]),
                .chain_i     (chain_in[gi]),
                .chain_sel_i (chain_sel[gi]),
                .preset_i    (preset[gi]),
                .comb_i      (comb[gi]),
                .reg_o       (reg_o[gi]),
                .cell_o      (cell_o[gi])
            );
        end
    endgenerate

    // own cells, left and right neighbours: 3 x 16 destinations
    assign dlink_l_o = cell_o;
    assign dlink_r_o = cell_o;
    assign chain_o   = reg_o[NCELL-1];

    // readback
    logic [31:0] status;
    assign status = {16'h0000, act_cnt[NCTRL], ng_pfx[NCTRL],
                     4'h0, gate_a_off, sload_req && pack_en, tick_b, tick_a};

    always_comb begin
        case (addr_i)
            A_SRC:      rdata_d = src_q;
            A_MODE:     rdata_d = mode_q;
            A_CELL_CLK: rdata_d = cclk_q;
            A_CELL_CLR: rdata_d = cclr_q;
            A_CELL_MOD: rdata_d = cmod_q;
            A_LOC0:     rdata_d = loc0_q;
            A_LOC1:     rdata_d = loc1_q;
            A_STATUS:   rdata_d = status;
            A_QOUT:     rdata_d = {16'h0000, reg_o};
            default:    rdata_d = ZERO_RST;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !rd_i) begin
            rdata_q <= ZERO_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    logic [NCELL-1:0] on_a;
    logic             no_clr;
    assign on_a   = ~on_b;
    assign no_clr = !dev_clr && !aclr0 && !aclr1;

    property p_active_limit;
        act_cnt[NCTRL] <= 4'(MAX_ACTIVE);
    endproperty
    a_active_limit: assert property (p_active_limit) else $error("too many controls");

    property p_sload_gate;
        sload_ok |-> !eff[LCRC_GATE_A] && gate_a;
    endproperty
    a_sload_gate: assert property (p_sload_gate) else $error("gate a live with sload");

    property p_pack_sload;
        pack_en |-> !eff[LCRC_SLOAD] && !sload;
    endproperty
    a_pack_sload: assert property (p_pack_sload) else $error("sload with packing");

    property p_nonglobal;
        ng_pfx[NCTRL] <= 4'(MAX_NONGLOBAL);
    endproperty
    a_nonglobal: assert property (p_nonglobal) else $error("non-global over four");

    property p_sclr_all;
        tick_a && sclr && no_clr |=> ((reg_o ^ preset) & on_a) == '0;
    endproperty
    a_sclr_all: assert property (p_sclr_all) else $error("sclr missed a cell");

    property p_gate_stop;
        !gate_a && no_clr && $stable(cclr_q) && $stable(cclk_q) |=> ($past(reg_o) & on_a) == (reg_o & on_a);
    endproperty
    a_gate_stop: assert property (p_gate_stop) else $error("gated clock updated");

    property p_devclr;
        dev_clr ##1 $stable(cclr_q) |-> (reg_o ^ preset) == '0;
    endproperty
    a_devclr: assert property (p_devclr) else $error("device clear failed");

    property p_chain;
        tick_a && no_clr && !sclr && !sload && chain_sel[1] && on_a[1] && !preset[1]
            && !preset[0] |=> reg_o[1] == $past(reg_o[0]);
    endproperty
    a_chain: assert property (p_chain) else $error("chain shift wrong");

    property p_bypass;
        (cell_o & comb) == (lut_i & comb);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken");

    property p_aclr_wins;
        aclr0 && sload |=> ((reg_o ^ preset) & ~clr_sel) == '0;
    endproperty
    a_aclr_wins: assert property (p_aclr_wins) else $error("aclr lost priority");

    property p_read_once;
        rd_i ##1 !rd_i |=> rdata_o == '0;
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data lingers");

    c_sload_tick: cover property (tick_a && sload);
    c_sclr_tick:  cover property (tick_b && sclr);
    c_both_edges: cover property (tick_a ##[1:8] tick_b);
    c_devclr:     cover property (dev_clr);
endmodule : lcrc_top
`default_nettype wire

/* lcrc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lcrc_top_tb
    import lcrc_pkg::*;
;
    logic             mclk_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic             dev_clr_n_i = 1'b1;
    logic             wr_i = 1'b0;
    logic             rd_i = 1'b0;
    logic [7:0]       addr_i = 8'h00;
    logic [31:0]      wdata_i = 32'h00000000;
    logic [31:0]      rdata_o;
    logic [31:0]      d;
    logic [NROW-1:0]  row_clk_i;
    logic [NRTE-1:0]  route_i;
    logic [NCELL-1:0] lut_i;
    logic [NCELL-1:0] sdata_i;
    logic [NCELL-1:0] left_i;
    logic [NCELL-1:0] right_i;
    logic [NCELL-1:0] cell_o;
    logic [NCELL-1:0] reg_o;
    logic [NCELL-1:0] dlink_l_o;
    logic [NCELL-1:0] dlink_r_o;
    logic             chain_i;
    logic             chain_o;
    int               err_count = 0;
    int               cmp_count = 0;

    always #20 mclk_i = ~mclk_i;

    lcrc_fab fab (.mclk_i(mclk_i), .row_o(row_clk_i), .rte_o(route_i), .lut_o(lut_i),
                  .sd_o(sdata_i), .lf_o(left_i), .rt_o(right_i), .ch_o(chain_i));
    lcrc_top #(.DEV_CLR_EN(1'b1)) uut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .dev_clr_n_i(dev_clr_n_i),
        .row_clk_i(row_clk_i), .route_i(route_i), .left_i(left_i), .right_i(right_i),
        .lut_i(lut_i), .sdata_i(sdata_i), .chain_i(chain_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cell_o(cell_o),
        .reg_o(reg_o), .dlink_l_o(dlink_l_o), .dlink_r_o(dlink_r_o), .chain_o(chain_o));

    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        cmp_count++;
        if (y !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, x, y);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    task automatic q(input string s, input logic [15:0] x);
        #1;
        chk(s, {16'h0000, x}, {16'h0000, reg_o});
    endtask : q
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    task automatic t_reset;
        logic [7:0] z [8] = '{A_MODE, A_CELL_CLK, A_CELL_CLR, A_CELL_MOD, A_LOC0, A_LOC1,
                              A_QOUT, 8'h24};
        rd(A_SRC);
        chk("src reset", SRC_RST, d);
        cyc(1);
        chk("rdata idle", ZERO_RST, rdata_o);
        wr(8'h24, SRC_RST);
        wr(A_QOUT, SRC_RST);
        foreach (z[i]) begin
            rd(z[i]);
            chk("zero reset", ZERO_RST, d);
        end
    endtask : t_reset
    task automatic t_cap;
        wr(A_SRC, 32'hFFFFFFF0);
        fab.put(16'hA5C3, 16'h0000, 1'b0);
        fab.pulse(0);
        q("capture", 16'hA5C3);
        chk("links", 32'hA5C3A5C3, {dlink_l_o, dlink_r_o});
        rd(A_QOUT);
        chk("qout", 32'h0000A5C3, d);
        wr(A_CELL_MOD, 32'h0000FF00);
        fab.put(16'h1234, 16'h0000, 1'b0);
        cyc(2);
        chk("bypass", 32'h000012C3, {16'h0000, cell_o});
        wr(A_CELL_MOD, ZERO_RST);
        wr(A_SRC, 32'hFFFFFF10);
        fab.pulse(0);
        q("gate low", 16'hA5C3);
        fab.line(1, 1'b1);
        cyc(2);
        fab.pulse(0);
        q("gate high", 16'h1234);
        fab.line(1, 1'b0);
    endtask : t_cap
    task automatic t_edge;
        wr(A_SRC, 32'hFFFFF0F0);
        wr(A_MODE, 32'h00000002);
        wr(A_CELL_CLK, 32'h0000FF00);
        fab.put(16'h3333, 16'h0000, 1'b0);
        fab.line(0, 1'b1);
        cyc(3);
        q("rising half", 16'h1233);
        fab.line(0, 1'b0);
        cyc(3);
        q("falling half", 16'h3333);
        wr(A_MODE, ZERO_RST);
        wr(A_CELL_CLK, ZERO_RST);
    endtask : t_edge
    task automatic t_sync;
        wr(A_SRC, 32'h32FFFFF0);
        fab.put(16'h3333, 16'h5A5A, 1'b0);
        fab.line(3, 1'b1);
        fab.pulse(0);
        q("sload", 16'h5A5A);
        fab.line(2, 1'b1);
        fab.pulse(0);
        q("sclr over sload", 16'h0000);
        fab.line(2, 1'b0);
        fab.line(3, 1'b0);
        fab.pulse(0);
        q("data again", 16'h3333);
        wr(A_SRC, 32'h3FFFFF10);
        fab.put(16'h3333, 16'h0FF0, 1'b0);
        fab.line(3, 1'b1);
        fab.pulse(0);
        q("sload opens gate", 16'h0FF0);
        rd(A_STATUS);
        chk("gate off flag", 32'h00000008, d & 32'h0000000C);
        wr(A_MODE, 32'h00000004);
        fab.line(1, 1'b1);
        fab.pulse(0);
        q("packing drops sload", 16'h3333);
        rd(A_STATUS);
        chk("packing flag", 32'h00000004, d & 32'h00000004);
        fab.line(1, 1'b0);
        fab.line(3, 1'b0);
        wr(A_MODE, ZERO_RST);
    endtask : t_sync
    task automatic t_chain;
        logic [15:0] x;
        x = 16'h3333;
        wr(A_SRC, 32'hFFFFFFF0);
        wr(A_CELL_MOD, 32'hFFFF0000);
        for (int i = 0; i < 4; i++) begin
            fab.put(16'h0000, 16'h0000, i[0] ^ i[1]);
            fab.pulse(0);
            x = {x[14:0], i[0] ^ i[1]};
            q("chain shift", x);
            chk("chain out", {31'h0, x[15]}, {31'h0, chain_o});
        end
        wr(A_CELL_MOD, ZERO_RST);
    endtask : t_chain
    task automatic t_clear;
        wr(A_SRC, 32'h3F45FFF0);
        wr(A_CELL_CLR, 32'h000FFF00);
        fab.put(16'hFFFF, 16'h0000, 1'b0);
        fab.pulse(0);
        q("preset load", 16'hFFFF);
        fab.line(3, 1'b1);
        fab.line(5, 1'b1);
        cyc(3);
        q("aclr0 preset", 16'hFF0F);
        fab.line(4, 1'b1);
        fab.pulse(0);
        q("aclr over clock", 16'h000F);
        fab.line(5, 1'b0);
        fab.line(4, 1'b0);
        fab.line(3, 1'b0);
        wr(A_CELL_CLR, ZERO_RST);
        wr(A_SRC, 32'hFFFFFFF0);
        fab.pulse(0);
        @(posedge mclk_i);
        dev_clr_n_i <= 1'b0;
        fab.pulse(0);
        q("device clear", 16'h0000);
        @(posedge mclk_i);
        dev_clr_n_i <= 1'b1;
    endtask : t_clear
    task automatic t_local;
        wr(A_SRC, 32'hFFFFFFF6);
        fab.put(16'h6699, 16'h0000, 1'b0);
        fab.pulse(NROW);
        q("local clock", 16'h6699);
        wr(A_LOC0, 32'h00000018);
        fab.put(16'h9966, 16'h0000, 1'b0);
        fab.pulse(NROW + NRTE);
        q("left link clock", 16'h9966);
        wr(A_LOC0, 32'h00000028);
        fab.put(16'h5AA5, 16'h0000, 1'b0);
        fab.pulse(NROW + NRTE + NCELL);
        q("right link clock", 16'h5AA5);
        wr(A_LOC0, ZERO_RST);
        wr(A_SRC, 32'hFFFA9876);
        rd(A_STATUS);
        chk("nonglobal count", 32'h00000400, d & 32'h00000F00);
        chk("active count", 32'h00004000, d & 32'h0000F000);
    endtask : t_local
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_cap();
        t_edge();
        t_sync();
        t_chain();
        t_clear();
        t_local();
        tally_and_finish();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end
endmodule : lcrc_top_tb
`default_nettype wire
